// ==== rtl/ras_alarm_status.sv ====
// Purpose: E1 receive alarm and event detection with status register
// Assumes: Inputs synchronous to CLOCK; framer supplies frame markers
// Notes: Status and pending bits clear on a read of the status register
//
// Notes on behaviour
// - TS16 under three zeros per 16 frames sets all-ones
// - TS16 all zero over multiframe sets all-zeros
// - Signaling change sets both signaling flags
// - Frame-0 TS16 bit 6 twice sets distant alarm
// - Distant alarm also active under common channel signaling
// - Elastic store frame slip sets slip flag
// - Under three zeros per 512 bits: unframed ones
// - Non-align bit 3 thrice sets remote alarm
// - 255 or 2048 zeros set carrier loss
// - 32 ones in 255 bits clear carrier loss
// - Loss-of-sync flag follows framer sync state
// - Alarm changes interrupt; read releases it
// - Events interrupt; read of bit releases it
// - Mask bit one lets status reach interrupt
`default_nettype none
module ras_alarm_status (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic CE,
    input wire ras_pkg::ras_line_t LINE,
    input wire logic IN_SYNC,
    input wire logic SLIP_EVENT,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic IRQ,
    output logic [7:0] ALARM_LEVELS
);
    import ras_pkg::*;

    // ****************************************************************
    // Frame position tracking
    // ****************************************************************
    logic [7:0] bit_idx_q;
    logic [7:0] bit_idx_d;
    logic [3:0] frame_q;
    logic [3:0] frame_d;
    logic strobe;
    logic line_mark;
    logic analog_mark;
    logic in_ts16;
    logic ts16_end;
    logic mf_end;

    assign strobe = CE && LINE.bit_strobe;
    assign line_mark = LINE.line_data_positive_in ||
        LINE.line_data_negative_in;
    assign analog_mark = LINE.analog_receive_plus ||
        LINE.analog_receive_minus;
    assign bit_idx_d = LINE.frame_start ? 8'h00 : bit_idx_q + 8'h01;
    assign frame_d = (LINE.frame_start && LINE.mframe_start) ? 4'h0 :
        LINE.frame_start ? frame_q + 4'h1 : frame_q;
    assign in_ts16 = IN_SYNC && (bit_idx_d >= RAS_TS16_FIRST) &&
        (bit_idx_d <= RAS_TS16_LAST);
    assign ts16_end = IN_SYNC && (bit_idx_d == RAS_TS16_LAST);
    assign mf_end = ts16_end &&
        (frame_d == 4'(RAS_FRAMES_PER_MF - 1));

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            bit_idx_q <= 8'h00;
            frame_q <= 4'h0;
        end else if (strobe) begin
            bit_idx_q <= bit_idx_d;
            frame_q <= frame_d;
        end
    end

    // ****************************************************************
    // Timeslot 16 density and signaling change
    // ****************************************************************
    logic [7:0] sig_mem [RAS_FRAMES_PER_MF];
    logic [15:0] sig_seen_q;
    logic [7:0] ts16_sh_q;
    logic [7:0] ts16_byte;
    logic [1:0] zeros_q;
    logic [1:0] zeros_d;
    logic ones_q;
    logic ones_d;
    logic sa1_q;
    logic sa0_q;
    logic sig_change;

    assign ts16_byte = {ts16_sh_q[6:0], line_mark};
    assign zeros_d = (!line_mark && zeros_q != RAS_SA1_ZEROS) ?
        zeros_q + 2'h1 : zeros_q;
    assign ones_d = ones_q || line_mark;
    // Frame 0 carries the alignment word, so it is not compared
    assign sig_change = strobe && ts16_end && (frame_d != 4'h0) &&
        sig_seen_q[frame_d] && (sig_mem[frame_d] != ts16_byte);

    always_ff @(posedge CLOCK) begin
        if (strobe && ts16_end) begin
            sig_mem[frame_d] <= ts16_byte;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            sig_seen_q <= 16'h0000;
            ts16_sh_q <= 8'h00;
            zeros_q <= 2'h0;
            ones_q <= 1'b0;
            sa1_q <= 1'b0;
            sa0_q <= 1'b0;
        end else if (strobe) begin
            if (!IN_SYNC) begin
                sig_seen_q <= 16'h0000;
            end else if (ts16_end) begin
                sig_seen_q[frame_d] <= 1'b1;
            end
            if (in_ts16) begin
                ts16_sh_q <= ts16_byte;
            end
            if (mf_end) begin
                zeros_q <= 2'h0;
                ones_q <= 1'b0;
                sa1_q <= (zeros_d != RAS_SA1_ZEROS);
                sa0_q <= !ones_d;
            end else if (in_ts16) begin
                zeros_q <= zeros_d;
                ones_q <= ones_d;
            end
        end
    end

    // ****************************************************************
    // Distant multiframe alarm and remote alarm
    // ****************************************************************
    logic [1:0] dma_run_q;
    logic dma_q;
    logic [1:0] ra_run_q;
    logic ra_q;
    logic dma_sample;
    logic ra_sample;

    // No signaling-mode gate: works under common channel signaling too
    assign dma_sample = strobe && IN_SYNC && (frame_d == 4'h0) &&
        (bit_idx_d == RAS_TS16_BIT6);
    assign ra_sample = strobe && IN_SYNC && frame_d[0] &&
        (bit_idx_d == RAS_NAF_BIT3);

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            dma_run_q <= 2'h0;
            dma_q <= 1'b0;
            ra_run_q <= 2'h0;
            ra_q <= 1'b0;
        end else begin
            if (dma_sample) begin
                if (line_mark == dma_q) begin
                    dma_run_q <= 2'h0;
                end else if (dma_run_q == RAS_DMA_COUNT - 2'h1) begin
                    dma_run_q <= 2'h0;
                    dma_q <= line_mark;
                end else begin
                    dma_run_q <= dma_run_q + 2'h1;
                end
            end
            if (ra_sample) begin
                if (line_mark == ra_q) begin
                    ra_run_q <= 2'h0;
                end else if (ra_run_q == RAS_RA_COUNT - 2'h1) begin
                    ra_run_q <= 2'h0;
                    ra_q <= line_mark;
                end else begin
                    ra_run_q <= ra_run_q + 2'h1;
                end
            end
        end
    end

    // ****************************************************************
    // Unframed all ones over 512-bit windows
    // ****************************************************************
    logic [8:0] ua1_win_q;
    logic [1:0] ua1_zeros_q;
    logic [1:0] ua1_zeros_d;
    logic ua1_q;

    assign ua1_zeros_d = (!line_mark && ua1_zeros_q != RAS_UA1_ZEROS) ?
        ua1_zeros_q + 2'h1 : ua1_zeros_q;

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ua1_win_q <= 9'h000;
            ua1_zeros_q <= 2'h0;
            ua1_q <= 1'b0;
        end else if (strobe) begin
            ua1_win_q <= ua1_win_q + 9'h001;
            if (ua1_win_q == RAS_UA1_WINDOW_LAST) begin
                ua1_zeros_q <= 2'h0;
                ua1_q <= (ua1_zeros_d != RAS_UA1_ZEROS);
            end else begin
                ua1_zeros_q <= ua1_zeros_d;
            end
        end
    end

    // ****************************************************************
    // Carrier loss
    // ****************************************************************
    logic [7:0] ctrl_q;
    logic cl_loss;

    ras_carrier_loss u_carrier_loss (
        .clk(CLOCK),
        .rst_n(RSTN),
        .ce(CE),
        .bit_strobe(LINE.bit_strobe),
        .mark(analog_mark),
        .thr_long(ctrl_q[RAS_CTRL_THR_BIT]),
        .loss(cl_loss)
    );

    // ****************************************************************
    // Status, pending and interrupt
    // ****************************************************************
    logic [7:0] level;
    logic [7:0] level_q;
    logic [7:0] force_set;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] pend_q;
    logic [7:0] pend_d;
    logic [7:0] pend_set;
    logic [7:0] mask_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic irq_q;
    logic rd_status;
    logic wr_mask;
    logic wr_ctrl;
    logic wr_status;

    assign level = {sa1_q, dma_q, sa0_q, CE && SLIP_EVENT,
        ua1_q, ra_q, cl_loss, !IN_SYNC};
    assign force_set = {sig_change, 1'b0, sig_change, 5'h00};
    // Events pend on their rising edge, alarms on either edge
    assign pend_set = force_set |
        (RAS_EVENT_BITS & level & ~level_q) |
        (RAS_ALARM_BITS & (level ^ level_q));

    assign rd_status = CE && RD && (ADDR == RAS_ADDR_STATUS);
    assign wr_status = CE && WR && (ADDR == RAS_ADDR_STATUS);
    assign wr_mask = CE && WR && (ADDR == RAS_ADDR_MASK);
    assign wr_ctrl = CE && WR && (ADDR == RAS_ADDR_CTRL);

    // A set in the cycle of the clearing read survives it
    assign status_d = (rd_status ? 8'h00 : status_q) |
        level | force_set;
    assign pend_d = (rd_status ? 8'h00 :
        (wr_status ? pend_q & ~WDATA : pend_q)) | pend_set;

    always_comb begin
        rdata_d = 8'h00;
        if (ADDR == RAS_ADDR_STATUS) begin
            rdata_d = status_q;
        end else if (ADDR == RAS_ADDR_MASK) begin
            rdata_d = mask_q;
        end else if (ADDR == RAS_ADDR_CTRL) begin
            rdata_d = ctrl_q;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            level_q <= 8'h00;
            status_q <= 8'h00;
            pend_q <= 8'h00;
            mask_q <= RAS_MASK_RESET;
            ctrl_q <= RAS_CTRL_RESET;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
        end else if (CE) begin
            level_q <= level;
            status_q <= status_d;
            pend_q <= pend_d;
            irq_q <= |(pend_d & mask_q);
            if (wr_mask) begin
                mask_q <= WDATA;
            end
            if (wr_ctrl) begin
                ctrl_q <= WDATA;
            end
            rdata_q <= RD ? rdata_d : 8'h00;
        end
    end

    assign RDATA = rdata_q;
    assign IRQ = irq_q;
    assign ALARM_LEVELS = level_q;
endmodule : ras_alarm_status
`default_nettype wire

// ==== rtl/ras_pkg.sv ====
// Purpose: Shared constants and types for the receive alarm status block
// Assumes: One 25 MHz clock; line bits arrive as one-cycle strobes
// Notes: Register offsets are byte addresses on the plain register port
`default_nettype none
package ras_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] RAS_ADDR_STATUS = 8'h06;
    localparam logic [7:0] RAS_ADDR_MASK = 8'h16;
    localparam logic [7:0] RAS_ADDR_CTRL = 8'h20;
    localparam logic [7:0] RAS_MASK_RESET = 8'h00;
    localparam logic [7:0] RAS_CTRL_RESET = 8'h00;
    localparam int RAS_CTRL_THR_BIT = 0;

    // ****************************************************************
    // Status bit positions
    // ****************************************************************
    localparam int RAS_BIT_SA1 = 7;
    localparam int RAS_BIT_DMA = 6;
    localparam int RAS_BIT_SA0 = 5;
    localparam int RAS_BIT_SLIP = 4;
    localparam int RAS_BIT_UA1 = 3;
    localparam int RAS_BIT_RA = 2;
    localparam int RAS_BIT_CL = 1;
    localparam int RAS_BIT_LOS = 0;
    localparam logic [7:0] RAS_EVENT_BITS = 8'hF0;
    localparam logic [7:0] RAS_ALARM_BITS = 8'h0F;

    // ****************************************************************
    // Frame geometry and detector thresholds
    // ****************************************************************
    localparam int RAS_FRAMES_PER_MF = 16;
    localparam logic [7:0] RAS_TS16_FIRST = 8'h80;
    localparam logic [7:0] RAS_TS16_LAST = 8'h87;
    localparam logic [7:0] RAS_TS16_BIT6 = 8'h85;
    localparam logic [7:0] RAS_NAF_BIT3 = 8'h02;
    localparam logic [1:0] RAS_SA1_ZEROS = 2'h3;
    localparam logic [1:0] RAS_DMA_COUNT = 2'h2;
    localparam logic [1:0] RAS_RA_COUNT = 2'h3;
    localparam logic [8:0] RAS_UA1_WINDOW_LAST = 9'h1FF;
    localparam logic [1:0] RAS_UA1_ZEROS = 2'h3;
    localparam logic [11:0] RAS_CL_ZEROS_SHORT = 12'h0FF;
    localparam logic [11:0] RAS_CL_ZEROS_LONG = 12'h800;
    localparam logic [7:0] RAS_CL_WINDOW_LAST = 8'hFE;
    localparam logic [5:0] RAS_CL_ONES = 6'h20;

    // ****************************************************************
    // Carrier for line-side inputs
    // ****************************************************************
    typedef struct packed {
        logic bit_strobe;
        logic frame_start;
        logic mframe_start;
        logic line_data_positive_in;
        logic line_data_negative_in;
        logic analog_receive_plus;
        logic analog_receive_minus;
    } ras_line_t;
endpackage : ras_pkg
`default_nettype wire

// ==== rtl/ras_carrier_loss.sv ====
// Purpose: Carrier loss detector on the analog receive marks
// Assumes: One strobe per received bit time
// Notes: Loss set by a run of zeros, cleared by ones density
`default_nettype none
module ras_carrier_loss (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic bit_strobe,
    input wire logic mark,
    input wire logic thr_long,
    output logic loss
);
    import ras_pkg::*;

    logic [11:0] zero_run_q;
    logic [11:0] zero_run_d;
    logic [7:0] win_q;
    logic [7:0] win_d;
    logic [5:0] ones_q;
    logic [5:0] ones_d;
    logic loss_q;
    logic loss_d;
    logic [11:0] thr;
    logic win_end;
    logic ones_met;

    assign thr = thr_long ? RAS_CL_ZEROS_LONG : RAS_CL_ZEROS_SHORT;
    assign win_end = (win_q == RAS_CL_WINDOW_LAST);
    assign ones_met = mark && (ones_q == RAS_CL_ONES - 6'h01);
    assign zero_run_d = mark ? 12'h000 :
        (zero_run_q == thr) ? zero_run_q : zero_run_q + 12'h001;
    assign win_d = (!loss_q || win_end) ? 8'h00 : win_q + 8'h01;
    assign ones_d = (!loss_q || win_end) ? 6'h00 :
        (ones_q == RAS_CL_ONES) ? ones_q : ones_q + {5'h00, mark};
    // Loss from a zero run; recovery on 32 ones inside a 255-bit window
    assign loss_d = !loss_q ? (!mark && zero_run_q + 12'h001 >= thr) :
        !ones_met;
    assign loss = loss_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_run_q <= 12'h000;
            win_q <= 8'h00;
            ones_q <= 6'h00;
            loss_q <= 1'b0;
        end else if (ce && bit_strobe) begin
            zero_run_q <= zero_run_d;
            win_q <= win_d;
            ones_q <= ones_d;
            loss_q <= loss_d;
        end
    end
endmodule : ras_carrier_loss
`default_nettype wire

// ==== verif/ras_alarm_status_assertions.sv ====
// Purpose: Port-level assertions for the receive alarm status block
// Assumes: Mask and threshold select are tracked from register writes
// Notes: Carrier zero runs are counted here from the analog marks
`default_nettype none
module ras_alarm_status_chk (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic CE,
    input wire ras_pkg::ras_line_t LINE,
    input wire logic IN_SYNC,
    input wire logic SLIP_EVENT,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic IRQ,
    input wire logic [7:0] ALARM_LEVELS
);
    timeunit 1ns;
    timeprecision 1ns;
    import ras_pkg::*;
    logic [7:0] mask_q;
    logic thr_q;
    logic [11:0] zc_q;
    wire logic mark = LINE.analog_receive_plus | LINE.analog_receive_minus;
    wire logic [11:0] lim = thr_q ? RAS_CL_ZEROS_LONG : RAS_CL_ZEROS_SHORT;
    wire logic [11:0] zc_d = mark ? 12'h000 : zc_q + {11'h000, ~&zc_q};
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            mask_q <= RAS_MASK_RESET;
            thr_q <= 1'b0;
            zc_q <= 12'h000;
        end else if (CE) begin
            if (WR && ADDR == RAS_ADDR_MASK) mask_q <= WDATA;
            if (WR && ADDR == RAS_ADDR_CTRL) thr_q <= WDATA[RAS_CTRL_THR_BIT];
            if (LINE.bit_strobe) zc_q <= zc_d;
        end
    end
    // ****************************************************************
    // Port relations
    // ****************************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    a_slip_level: assert property (
        CE && SLIP_EVENT |=> ALARM_LEVELS[RAS_BIT_SLIP])
        else $error("slip missing from levels");
    a_slip_irq: assert property (
        CE && SLIP_EVENT && mask_q[RAS_BIT_SLIP] |=> IRQ)
        else $error("unmasked slip gave no interrupt");
    a_slip_latch: assert property (
        CE && SLIP_EVENT ##1 CE && RD && ADDR == RAS_ADDR_STATUS
        |=> RDATA[RAS_BIT_SLIP]) else $error("slip not latched");
    a_los_level: assert property (
        CE && !IN_SYNC |=> ALARM_LEVELS[RAS_BIT_LOS])
        else $error("sync loss not shown");
    a_irq_masked: assert property (
        mask_q == 8'h00 && $past(mask_q) == 8'h00 |-> !IRQ)
        else $error("interrupt with all bits masked");
    a_mask_echo: assert property (
        CE && RD && ADDR == RAS_ADDR_MASK |=> RDATA == mask_q)
        else $error("mask read back wrong");
    a_rd_idle: assert property (
        CE && !RD |=> RDATA == 8'h00) else $error("read data not idle");
    a_cl_early: assert property (
        $rose(ALARM_LEVELS[RAS_BIT_CL]) |-> zc_q >= lim)
        else $error("carrier loss before zero run");
    a_cl_set: assert property (
        CE && zc_q == lim |-> ##[1:4] ALARM_LEVELS[RAS_BIT_CL])
        else $error("carrier loss late");
endmodule : ras_alarm_status_chk
bind ras_alarm_status ras_alarm_status_chk i_chk (.CLOCK(CLOCK),
    .RSTN(RSTN), .CE(CE), .LINE(LINE), .IN_SYNC(IN_SYNC),
    .SLIP_EVENT(SLIP_EVENT), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .ALARM_LEVELS(ALARM_LEVELS));
`default_nettype wire

// ==== verif/ras_line_model.sv ====
// Purpose: Receive line source feeding the alarm status block
// Assumes: One bit every second clock; 256 bits a frame, 16 a multiframe
// Notes: Positive data line shows the inverse bit between strobes; negative stays low
`default_nettype none
module ras_line_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] ts16,
    input wire logic naf3,
    input wire logic data_one,
    input wire logic amark,
    output wire ras_pkg::ras_line_t line
);
    timeunit 1ns;
    timeprecision 1ns;
    import ras_pkg::*;
    logic stb_q;
    logic [7:0] idx_q;
    logic [3:0] fr_q;
    // ****************************************************************
    // Frame counters and bit source
    // ****************************************************************
    wire logic sig = idx_q >= RAS_TS16_FIRST && idx_q <= RAS_TS16_LAST;
    wire logic naf = idx_q == RAS_NAF_BIT3 && fr_q[0];
    wire logic b = sig ? ts16[~idx_q[2:0]] : (naf ? naf3 : data_one);
    wire logic f0 = stb_q && idx_q == 8'h00;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stb_q <= 1'b0;
            idx_q <= 8'h00;
            fr_q <= 4'h0;
        end else begin
            stb_q <= ~stb_q;
            if (stb_q) idx_q <= idx_q + 8'h01;
            if (stb_q && idx_q == 8'hFF) fr_q <= fr_q + 4'h1;
        end
    end
    assign line = '{stb_q, f0, f0 && fr_q == 4'h0, stb_q ? b : ~b, 1'b0,
        stb_q ? amark : ~amark, 1'b0};
endmodule : ras_line_model
`default_nettype wire

// ==== verif/tb_ras_alarm_status.sv ====
// Purpose: Self-checking bench for the receive alarm status block
// Assumes: CE held high; line source strobes every second clock
// Notes: Waits cover the worst alignment of each set or clear count
`default_nettype none
module tb_ras_alarm_status;
    timeunit 1ns;
    timeprecision 1ns;
    import ras_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, in_sync = 1'b0;
    logic slip = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic naf3 = 1'b0, data_one = 1'b0, amark = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, ts16 = 8'hF0, got;
    wire logic [7:0] rdata, levels;
    wire logic irq;
    wire ras_line_t line_s;
    int n_errors = 0, samples_checked = 0, cycles = 0;
    ras_alarm_status i_ras_alarm_status (.CLOCK(clk), .RSTN(rst_n), .CE(ce),
        .LINE(line_s), .IN_SYNC(in_sync), .SLIP_EVENT(slip), .ADDR(addr),
        .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .IRQ(irq),
        .ALARM_LEVELS(levels));
    ras_line_model i_ras_line_model (.clk(clk), .rst_n(rst_n), .ts16(ts16),
        .naf3(naf3), .data_one(data_one), .amark(amark), .line(line_s));
    initial forever #20 clk = ~clk;
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic lv(input logic [7:0] m, input logic [7:0] e);
        check(levels & m, e);
    endtask : lv
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        got = rdata;
    endtask : bus_rd
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        bus_rd(RAS_ADDR_STATUS);
        check(got, 8'h01);
        bus_rd(RAS_ADDR_MASK);
        check(got, RAS_MASK_RESET);
        bus_rd(RAS_ADDR_CTRL);
        check(got, RAS_CTRL_RESET);
        bus_rd(8'h7F);
        check(got, 8'h00);
        @(posedge clk);
        in_sync <= 1'b1;
        cyc(3);
        lv(8'h01, 8'h00);
        bus_rd(RAS_ADDR_STATUS);
        check(got & 8'h01, 8'h01);
        bus_rd(RAS_ADDR_STATUS);
        check(got & 8'h01, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_slip;
        bus_wr(RAS_ADDR_MASK, 8'h10);
        bus_rd(RAS_ADDR_STATUS);
        @(posedge clk);
        slip <= 1'b1;
        @(posedge clk);
        slip <= 1'b0;
        addr <= RAS_ADDR_STATUS;
        rd_s <= 1'b1;
        #1;
        check({7'h00, irq}, 8'h01);
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check(rdata & 8'h10, 8'h10);
        cyc(2);
        check({7'h00, irq}, 8'h00);
        bus_rd(RAS_ADDR_STATUS);
        check(got & 8'h10, 8'h00);
        $display("test slip done");
    endtask : t_slip
    task automatic t_carrier;
        bus_wr(RAS_ADDR_MASK, 8'h02);
        bus_rd(RAS_ADDR_STATUS);
        @(posedge clk);
        amark <= 1'b0;
        cyc(500);
        lv(8'h02, 8'h00);
        cyc(30);
        lv(8'h02, 8'h02);
        check({7'h00, irq}, 8'h01);
        bus_rd(RAS_ADDR_STATUS);
        cyc(2);
        check({7'h00, irq}, 8'h00);
        @(posedge clk);
        amark <= 1'b1;
        cyc(1100);
        lv(8'h02, 8'h00);
        check({7'h00, irq}, 8'h01);
        bus_wr(RAS_ADDR_CTRL, 8'h01);
        amark <= 1'b0;
        cyc(4000);
        lv(8'h02, 8'h00);
        cyc(200);
        lv(8'h02, 8'h02);
        @(posedge clk);
        amark <= 1'b1;
        cyc(1100);
        lv(8'h02, 8'h00);
        bus_wr(RAS_ADDR_MASK, 8'h00);
        $display("test carrier done");
    endtask : t_carrier
    task automatic t_signal;
        logic [7:0] tv [3] = '{8'h00, 8'hFF, 8'hF0};
        logic [7:0] ev [3] = '{8'h20, 8'hC0, 8'h00};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            ts16 <= tv[i];
            cyc(17000);
            lv(8'hE0, ev[i]);
        end
        bus_rd(RAS_ADDR_STATUS);
        @(posedge clk);
        ts16 <= 8'hE1;
        cyc(9000);
        bus_rd(RAS_ADDR_STATUS);
        check(got & 8'hE0, 8'hA0);
        $display("test signaling done");
    endtask : t_signal
    task automatic t_remote;
        @(posedge clk);
        ts16 <= 8'hFF;
        naf3 <= 1'b1;
        data_one <= 1'b1;
        cyc(4200);
        lv(8'h0C, 8'h0C);
        @(posedge clk);
        naf3 <= 1'b0;
        data_one <= 1'b0;
        cyc(4200);
        lv(8'h0C, 8'h00);
        $display("test remote done");
    endtask : t_remote
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_slip();
        t_carrier();
        t_signal();
        t_remote();
        give_verdict();
    end
endmodule : tb_ras_alarm_status
`default_nettype wire
